/* dcc_params.svh */
// Purpose: Shared constants of the dual channel transmit configuration block
// Assumes: Included by the package and by the design modules
// Notes: Widths are fixed; no run-time sizing
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

// Number of message buffers and index width
`define DCC_NUM_MB 16
`define DCC_MB_IDX_W 4
// Slot counter width
`define DCC_SLOT_W 11
// Channel assignment bit positions inside each buffer's two bits
`define DCC_ASG_A 0
`define DCC_ASG_B 1
// Reset values
`define DCC_ASG_RST 2'h0
`define DCC_SLOT_RST 11'h000
`define DCC_CFG_RST 3'h0

`endif

/* dcc_pkg.sv */
// Purpose: Types shared by the channel configuration modules
// Assumes: dcc_params.svh holds every number
// Notes: Structs carry related signals together
`include "dcc_params.svh"

package dcc_pkg;

    typedef struct packed {
        logic single_sel;
        logic first_en;
        logic second_en;
    } dcc_cfg_t;

    typedef struct packed {
        logic we;
        logic [`DCC_MB_IDX_W-1:0] idx;
        logic [1:0] val;
    } dcc_asg_wr_t;

    typedef struct packed {
        logic req;
        logic [`DCC_MB_IDX_W-1:0] idx;
    } dcc_tx_req_t;

    typedef struct packed {
        logic port_a;
        logic port_b;
        logic drop;
    } dcc_tx_out_t;

    typedef enum logic {
        DCC_READY,
        DCC_ACK_WAIT
    } dcc_ack_t;

    typedef struct packed {
        logic [`DCC_SLOT_W-1:0] count;
    } dcc_ctr_state_t;

    typedef struct packed {
        dcc_cfg_t cfg;
        logic [`DCC_NUM_MB-1:0][1:0] asg;
        dcc_ack_t ack;
        dcc_tx_out_t out;
        logic static_seg;
        logic dual;
        logic int_a_act;
        logic port_b_act;
        logic b_on_a;
    } dcc_state_t;

endpackage

/* dcc_slot_ctr.sv */
// Purpose: Slot counter of one internal channel
// Assumes: Tick and cycle start come from logic on the same clock
// Notes: Cycle start wins over a tick in the same cycle
`timescale 1ns/10ps
`include "dcc_params.svh"

module dcc_slot_ctr (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic cycle_start_i,
    input wire logic tick_i,
    output logic [`DCC_SLOT_W-1:0] count_o
);
    import dcc_pkg::*;

    dcc_ctr_state_t st;
    dcc_ctr_state_t next_st;

    always_comb begin
        next_st = st;
        if (cycle_start_i) begin
            next_st.count = `DCC_SLOT_RST;
        end else if (tick_i) begin
            next_st.count = st.count + `DCC_SLOT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st.count <= `DCC_SLOT_RST;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign count_o = st.count;

endmodule

/* dcc_chan_cfg.sv */
// Purpose: Channel mode, channel enables and per-buffer channel routing
// Assumes: Requests, ticks and acks come from logic on clk_sys_i
// Notes: Reproduces the lost channel B frame of the dual mode with the
//        first channel off; see the missed-slot path below
`timescale 1ns/10ps
`include "dcc_params.svh"

module dcc_chan_cfg (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic comm_active_i,
    input dcc_pkg::dcc_cfg_t cfg_i,
    input dcc_pkg::dcc_asg_wr_t asg_wr_i,
    input dcc_pkg::dcc_tx_req_t tx_req_i,
    input wire logic cycle_start_i,
    input wire logic [1:0] slot_tick_i,
    input wire logic ack_a_i,
    input wire logic [`DCC_SLOT_W-1:0] static_slots_i,
    output logic port_a_tx_o,
    output logic port_b_tx_o,
    output logic tx_drop_o,
    output logic static_seg_o,
    output logic dual_mode_o,
    output logic int_a_active_o,
    output logic port_b_active_o,
    output logic b_on_port_a_o
);
    import dcc_pkg::*;

    // ************************************************
    // Slot counters
    // ************************************************
    logic [1:0][`DCC_SLOT_W-1:0] slot_cnt;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ctr
            dcc_slot_ctr u_ctr (
                .clk_sys_i(clk_sys_i),
                .srst_i(srst_i),
                .ce_i(ce_i),
                .cycle_start_i(cycle_start_i),
                .tick_i(slot_tick_i[g]),
                .count_o(slot_cnt[g])
            );
        end
    endgenerate

    // ************************************************
    // Configuration decode
    // ************************************************
    function automatic logic int_a_on(input dcc_cfg_t c);
        int_a_on = c.first_en | (c.single_sel & c.second_en);
    endfunction

    function automatic logic emul_b(input dcc_cfg_t c);
        emul_b = c.single_sel & c.second_en & ~c.first_en;
    endfunction

    dcc_state_t st;
    dcc_state_t next_st;

    logic dual;
    logic int_b_on;
    logic errata_cfg;
    logic both_cfg;
    logic dyn_b;
    logic [1:0] asg_sel;
    logic want_a;
    logic send_a;
    logic send_b;

    always_comb begin
        dual = ~st.cfg.single_sel;
        int_b_on = dual & st.cfg.second_en;
        errata_cfg = dual & ~st.cfg.first_en & st.cfg.second_en;
        both_cfg = dual & st.cfg.first_en & st.cfg.second_en;
        dyn_b = slot_cnt[1] >= static_slots_i;
        asg_sel = st.asg[tx_req_i.idx];
        // In emulation the internal A logic serves buffers routed to B
        want_a = emul_b(st.cfg) ? asg_sel[`DCC_ASG_B]
                                : asg_sel[`DCC_ASG_A];
        send_a = int_a_on(st.cfg) & want_a;
        send_b = int_b_on & asg_sel[`DCC_ASG_B];
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.out = '0;
        // Changing mode mid-cycle would desync the slot counters
        if (!comm_active_i) begin
            next_st.cfg = cfg_i;
        end
        if (asg_wr_i.we) begin
            next_st.asg[asg_wr_i.idx] = asg_wr_i.val;
        end
        if (cycle_start_i) begin
            next_st.ack = DCC_READY;
        end
        case (st.ack)
            DCC_READY: begin
                if (tx_req_i.req) begin
                    next_st.out.port_a = send_a;
                    next_st.out.port_b = send_b;
                    // Ack is expected from the A side, which is off here
                    if (errata_cfg && dyn_b && send_b) begin
                        next_st.ack = DCC_ACK_WAIT;
                    end
                end
            end
            DCC_ACK_WAIT: begin
                if (tx_req_i.req) begin
                    next_st.out.port_a = send_a;
                    next_st.out.port_b = 1'b0;
                    next_st.out.drop = asg_sel[`DCC_ASG_B];
                    next_st.ack = DCC_READY;
                end else if (ack_a_i && int_a_on(st.cfg)) begin
                    next_st.ack = DCC_READY;
                end
            end
            default: begin
                next_st.ack = DCC_READY;
            end
        endcase
        // Boundary ignores channel B even when static buffers use B only
        next_st.static_seg = slot_cnt[0] < static_slots_i;
        next_st.dual = ~next_st.cfg.single_sel;
        next_st.int_a_act = int_a_on(next_st.cfg);
        next_st.port_b_act = ~next_st.cfg.single_sel
                             & next_st.cfg.second_en;
        next_st.b_on_a = emul_b(next_st.cfg);
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st.cfg <= `DCC_CFG_RST;
            st.asg <= {`DCC_NUM_MB{`DCC_ASG_RST}};
            st.ack <= DCC_READY;
            st.out <= '0;
            st.static_seg <= 1'b0;
            st.dual <= 1'b1;
            st.int_a_act <= 1'b0;
            st.port_b_act <= 1'b0;
            st.b_on_a <= 1'b0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign port_a_tx_o = st.out.port_a;
    assign port_b_tx_o = st.out.port_b;
    assign tx_drop_o = st.out.drop;
    assign static_seg_o = st.static_seg;
    assign dual_mode_o = st.dual;
    assign int_a_active_o = st.int_a_act;
    assign port_b_active_o = st.port_b_act;
    assign b_on_port_a_o = st.b_on_a;

    // ************************************************
    // Assertions
    // ************************************************
    dual_mode_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && !comm_active_i |=> dual_mode_o == !$past(cfg_i.single_sel))
    else $error("dual mode flag does not follow select bit");

    chan_enable_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && tx_req_i.req && dual && st.cfg.first_en
        && st.ack == DCC_READY && asg_sel[`DCC_ASG_A]
        |=> port_a_tx_o)
    else $error("enabled channel A did not transmit");

    asg_route_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && asg_wr_i.we && asg_wr_i.val == 2'h1 && both_cfg
        && comm_active_i ##1 !asg_wr_i.we
        ##1 ce_i && tx_req_i.req && both_cfg
        && tx_req_i.idx == $past(asg_wr_i.idx, 2)
        |=> port_a_tx_o && !port_b_tx_o)
    else $error("buffer routed to A only went elsewhere");

    static_bound_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i |=> static_seg_o == $past(slot_cnt[0] < static_slots_i))
    else $error("static boundary not from channel A counter");

    missed_slot_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && tx_req_i.req && st.ack == DCC_ACK_WAIT
        && asg_sel[`DCC_ASG_B] |=> tx_drop_o && !port_b_tx_o)
    else $error("frame after unacked minislot not dropped");

    emulate_b_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && tx_req_i.req && emul_b(st.cfg) && st.ack == DCC_READY
        && asg_sel[`DCC_ASG_B] |=> port_a_tx_o)
    else $error("channel B frame not sent by internal A logic");

    port_b_quiet_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && st.cfg.single_sel |=> !port_b_tx_o)
    else $error("port B active in single channel mode");

    both_enabled_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && tx_req_i.req && both_cfg && asg_sel[`DCC_ASG_B]
        |=> port_b_tx_o && !tx_drop_o)
    else $error("channel B frame lost with both channels on");

    cfg_hold_a:
    assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && comm_active_i |=> $stable(st.cfg))
    else $error("configuration changed during communication");

endmodule

/* dcc_xcvr_model.sv */
// Purpose: Bus transceivers standing on ports A and B of the channel block
// Assumes: Frame pulses are one clock wide and registered by the block
// Notes: Only counts frames; no line coding is modelled
`timescale 1ns/10ps

module dcc_xcvr_model (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic port_a_tx_i,
    input wire logic port_b_tx_i,
    output int frames_a_o,
    output int frames_b_o
);
    // ********************************
    // Frame counters per port
    // ********************************
    // Each port drives its own bus; port B carries the channel B frames of the dual mode
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            frames_a_o <= 0;
            frames_b_o <= 0;
        end else begin
            frames_a_o <= frames_a_o + int'(port_a_tx_i);
            frames_b_o <= frames_b_o + int'(port_b_tx_i);
        end
    end
endmodule

/* tb_dcc_chan_cfg.sv */
// Purpose: Self-checking bench of the channel configuration block
// Assumes: Inputs change on the falling edge; outputs read there too
// Notes: Slot counters stay at 0 during traffic, so B frames are dynamic
`timescale 1ns/10ps
`include "dcc_params.svh"

module tb_dcc_chan_cfg;
    import dcc_pkg::*;
    logic clk_sys_i = 0, srst_i = 1, ce_i = 1, comm_active_i = 1;
    logic cycle_start_i = 0, ack_a_i = 0, req_seen = 0, ackw = 0;
    logic pa, pb, drp, sseg, dual, inta, pbact, bona;
    logic [1:0] slot_tick_i = 2'h0;
    logic [`DCC_SLOT_W-1:0] static_slots_i = '0;
    logic [1:0] asg [`DCC_NUM_MB] = '{default: 2'h0};
    logic [2:0] q [$];
    logic [2:0] modes [5] = '{3'h3, 3'h5, 3'h1, 3'h7, 3'h4};
    dcc_cfg_t cfg_i = '0, cur;
    dcc_asg_wr_t asg_wr_i = '0;
    dcc_tx_req_t tx_req_i = '0;
    int n_errors = 0, n_checks = 0, seed = 36, na, nb, nb0, na0;

    always #5 clk_sys_i = ~clk_sys_i;

    dcc_chan_cfg i_dcc_chan_cfg (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .ce_i(ce_i), .comm_active_i(comm_active_i), .cfg_i(cfg_i),
        .asg_wr_i(asg_wr_i), .tx_req_i(tx_req_i),
        .cycle_start_i(cycle_start_i), .slot_tick_i(slot_tick_i),
        .ack_a_i(ack_a_i), .static_slots_i(static_slots_i),
        .port_a_tx_o(pa), .port_b_tx_o(pb), .tx_drop_o(drp),
        .static_seg_o(sseg), .dual_mode_o(dual), .int_a_active_o(inta),
        .port_b_active_o(pbact), .b_on_port_a_o(bona));
    dcc_xcvr_model i_dcc_xcvr_model (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .port_a_tx_i(pa), .port_b_tx_i(pb),
        .frames_a_o(na), .frames_b_o(nb));

    // ********************************
    // Compare and drive tasks
    // ********************************
    task automatic cmp_tx(input logic [2:0] e, input logic [2:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_st(input logic [3:0] e, input logic [3:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    function automatic logic [3:0] st_exp(input logic [2:0] c);
        return {!c[2], c[1] | (c[2] & c[0]), !c[2] & c[0], c[2] & c[0] & !c[1]};
    endfunction
    task automatic set_cfg(input logic [2:0] c);
        @(negedge clk_sys_i) cfg_i = c;
        comm_active_i = 0;
        cur = c;
        @(negedge clk_sys_i) comm_active_i = 1;
        cycle_start_i = 1;
        ackw = 0;
        @(negedge clk_sys_i) cycle_start_i = 0;
        cmp_st(st_exp(c), {dual, inta, pbact, bona});
    endtask
    task automatic wr(input int i, input logic [1:0] v);
        @(negedge clk_sys_i) asg_wr_i = {1'h1, 4'(i), v};
        asg[i] = v;
        @(negedge clk_sys_i) asg_wr_i = '0;
    endtask
    task automatic req(input int i);
        logic [1:0] v;
        logic a, b, d;
        v = asg[i];
        a = (cur.first_en | (cur.single_sel & cur.second_en))
            & ((cur.single_sel & cur.second_en & !cur.first_en) ? v[1] : v[0]);
        b = !cur.single_sel & cur.second_en & v[1];
        d = 0;
        // Lost frame follows a dynamic B frame when the next request routes to B in this mode
        if (!cur.single_sel & !cur.first_en & cur.second_en) begin
            if (ackw) begin
                d = v[1];
                b = 0;
                ackw = 0;
            end else if (b) begin
                ackw = 1;
            end
        end
        q.push_back({a, b, d});
        @(negedge clk_sys_i) tx_req_i = {1'h1, 4'(i)};
        ack_a_i = 1'($random(seed));
        @(negedge clk_sys_i) tx_req_i = '0;
    endtask
    task automatic tick(input logic [1:0] t, input int n);
        repeat (n) begin
            @(negedge clk_sys_i) slot_tick_i = t;
            @(negedge clk_sys_i) slot_tick_i = 2'h0;
        end
        @(negedge clk_sys_i);
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ********************************
    // Result watcher
    // ********************************
    always @(posedge clk_sys_i) req_seen <= tx_req_i.req;
    always @(negedge clk_sys_i) begin
        if (!srst_i)
            cmp_tx(req_seen ? q.pop_front() : 3'h0, {pa, pb, drp});
    end

    initial begin
        #50000;
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i) srst_i = 0;
        cmp_st(4'h8, {dual, inta, pbact, bona});
        for (int c = 0; c < 8; c++) set_cfg(3'(c));
        $display("done: mode table");
        @(negedge clk_sys_i) cfg_i = 3'h4;
        repeat (2) @(negedge clk_sys_i);
        cmp_st(st_exp(3'h7), {dual, inta, pbact, bona});
        $display("done: refused config");
        foreach (modes[m]) begin
            set_cfg(modes[m]);
            nb0 = nb;
            na0 = na;
            for (int k = 0; k < 12; k++) begin
                if (k < 4) wr(k, 2'(k));
                else wr($random(seed) & 15, 2'($random(seed)));
                req(k < 4 ? k : $random(seed) & 15);
                req($random(seed) & 15);
            end
            repeat (2) @(negedge clk_sys_i);
            // Emulated B frames must all leave through port A
            if (modes[m] == 3'h5) begin
                cmp_st(4'h0, {3'h0, nb != nb0});
                cmp_st(4'h1, {3'h0, na != na0});
            end
            $display("done: traffic mode %h", modes[m]);
        end
        set_cfg(3'h3);
        static_slots_i = 11'h002;
        tick(2'h0, 1);
        cmp_st(4'h1, {3'h0, sseg});
        tick(2'h2, 3);
        cmp_st(4'h1, {3'h0, sseg});
        // Clock enable low must freeze the channel A counter
        ce_i = 0;
        tick(2'h1, 2);
        cmp_st(4'h1, {3'h0, sseg});
        ce_i = 1;
        tick(2'h1, 2);
        cmp_st(4'h0, {3'h0, sseg});
        $display("done: static boundary");
        @(negedge clk_sys_i) srst_i = 1;
        @(negedge clk_sys_i) srst_i = 0;
        cmp_st(4'h8, {dual, inta, pbact, bona});
        @(negedge clk_sys_i);
        cmp_st(4'h8, {dual, inta, pbact, bona});
        $display("done: reset again");
        finish_test();
    end
endmodule
